// ==== verilog/swt_consts.svh ====
// constants for the bcd stopwatch timer: offsets, fields, reset values, timing
`ifndef SWT_CONSTS_SVH
`define SWT_CONSTS_SVH
`define SWT_ADDR_W        16
`define SWT_OFF_MS        16'hff4b
`define SWT_OFF_HS        16'hff4c
`define SWT_OFF_TS        16'hff4d
`define SWT_OFF_CTRL      16'hff4e
`define SWT_OFF_CFG       16'hff4f
`define SWT_CTRL_RUN_BIT  0
`define SWT_CTRL_RST_BIT  1
`define SWT_CTRL_CRNW_BIT 2
`define SWT_CFG_CKE_BIT   0
`define SWT_CFG_DIR_BIT   1
`define SWT_DIGIT_RST     4'h0
`define SWT_DIGIT_MAX     4'h9
`define SWT_OSC_DIV       32
`define SWT_SYS_HZ        50000000
`define SWT_OSC_HZ        32768
`define SWT_TICK_DIV      (`SWT_SYS_HZ / (2 * (`SWT_OSC_HZ / `SWT_OSC_DIV)))
`endif

// ==== verilog/swt_pkg.sv ====
// types for the bcd stopwatch timer
package swt_pkg;
	typedef logic [3:0] bcd_t;
	typedef enum logic [1:0] {
		HOLD_IDLE,
		HOLD_READ,
		HOLD_SPLIT
	} hold_e;
endpackage

// ==== verilog/bcd_stopwatch_timer.sv ====
// bcd stopwatch timer: prescaler, three bcd digits, capture buffer, run control
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/100ps
`include "swt_consts.svh"
module bcd_stopwatch_timer
	import swt_pkg::*;
#(
	parameter int TICK_DIV = `SWT_TICK_DIV	// sys clocks per oscillator/32 half-phase
) (
	input  wire logic                   sys_clk_i,    // 50 mhz system clock
	input  wire logic                   resetn_i,     // async reset, active low
	input  wire logic                   clk_en_i,     // freezes all state while low
	input  wire logic [`SWT_ADDR_W-1:0] addr_i,       // register address
	input  wire logic [3:0]             wdata_i,      // write data
	input  wire logic                   wr_i,         // write strobe
	input  wire logic                   rd_i,         // read strobe
	output logic [3:0]                  rdata_o,      // read data, cycle after rd_i
	input  wire logic                   split_key_i,  // split event pulse, one cycle
	input  wire logic                   run_key_i,    // direct run toggle pulse
	output logic                        carry_1hz_o,  // tenth digit wrap pulse
	output logic                        carry_10hz_o  // hundredth digit wrap pulse
);
	import swt_pkg::*;

	// overview of the data path:
	// - a reference divider stands in for the oscillator over 32
	// - its phase flag toggles every TICK_DIV enabled clocks
	// - the falling event of that phase is the 1024 hz prescaler input
	// - while running, the prescaler passes each falling event as a tick unless a drop waits
	// - a drop is armed whenever the count lands on a correction value
	// - ticks feed the millisecond digit, whose wrap feeds the hundredth digit
	// - the hundredth wrap feeds the tenth digit, whose wrap is the 1 hz carry
	// - the capture buffer copies all three digits in one clock
	// - a millisecond read or a split pulse loads the buffer
	// - the hold machine decides whether middle and top reads see the buffer
	// - run requests only reach the counters on a falling event
	//
	// hazards kept in mind:
	// - a read of the top digit and a split in one clock must keep the hold
	// - a counter reset and a tick in one clock: the reset wins
	// - a counter reset clears a pending drop and must not re-arm one by accident
	// - all state, the divider included, freezes while clk_en_i is low
	// - stopping the clock enable bit stops the divider where it stands

	// registers
	logic        cke_r, cke_nxt;
	logic        dir_r, dir_nxt;
	logic        run_req_r, run_req_nxt;
	logic        running_r, running_nxt;
	logic        crnw_r, crnw_nxt;
	logic        drop_r, drop_nxt;
	logic        ph_r;
	logic [31:0] div_r;
	bcd_t        dig_r [3];
	bcd_t        buf_r [3];
	hold_e       hold_r, hold_nxt;
	logic [3:0]  rdata_r;
	logic        c1_r, c10_r;

	// bus decode
	wire sel_ms   = (addr_i == `SWT_OFF_MS);
	wire sel_hs   = (addr_i == `SWT_OFF_HS);
	wire sel_ts   = (addr_i == `SWT_OFF_TS);
	wire sel_ctrl = (addr_i == `SWT_OFF_CTRL);
	wire sel_cfg  = (addr_i == `SWT_OFF_CFG);
	wire rd_ms    = rd_i & sel_ms;
	wire rd_ts    = rd_i & sel_ts;
	wire wr_ctrl  = wr_i & sel_ctrl;
	wire wr_cfg   = wr_i & sel_cfg;
	wire cnt_rst  = wr_ctrl & wdata_i[`SWT_CTRL_RST_BIT];

	// oscillator/32 reference divided from the system clock, gated by enable
	wire div_end  = (div_r == 32'(TICK_DIV - 1));
	wire fall_1k  = cke_r & div_end & ph_r;

	// prescaler: tick unless the correction drop is pending
	wire tick     = fall_1k & running_r & ~drop_r;

	// digit cascade carries
	wire wrap0    = tick & (dig_r[0] == `SWT_DIGIT_MAX);
	wire wrap1    = wrap0 & (dig_r[1] == `SWT_DIGIT_MAX);
	wire wrap2    = wrap1 & (dig_r[2] == `SWT_DIGIT_MAX);

	// correction table: twenty four values per thousand ticks
	// every value ends in nine, so the tick that lands on one starts
	// from an eight in the millisecond digit with the upper digits unchanged
	// the upper digits fall in two groups:
	// - tenth digit 0, 1, 4, 5, 8 or 9: hundredth digit 3 or 7
	// - tenth digit 2, 3, 6 or 7: hundredth digit 1, 5 or 9
	// that is six times two plus four times three, twenty four in all
	// the drop is armed by the landing tick and eats the next falling event
	wire [3:0] d1 = dig_r[1];
	wire [3:0] d2 = dig_r[2];
	wire grp_a    = (d2 == 4'h0) | (d2 == 4'h1) | (d2 == 4'h4) |
		(d2 == 4'h5) | (d2 == 4'h8) | (d2 == 4'h9);
	wire tens_a   = (d1 == 4'h3) | (d1 == 4'h7);
	wire tens_b   = (d1 == 4'h1) | (d1 == 4'h5) | (d1 == 4'h9);
	wire is_corr  = (dig_r[0] == 4'h8) & (grp_a ? tens_a : tens_b);
	wire arm_drop = tick & is_corr & ~cnt_rst;

	// capture triggers
	wire cap_read  = rd_ms;
	wire cap_split = split_key_i;
	wire capture   = cap_read | cap_split;

	// read path notes:
	// - the millisecond digit always reads live; its read is the capture
	// - middle and top digits read the buffer only while a hold stands
	// - without a hold they read live, which may tear while running
	// - the counter reset bit never reads back; the renewal flag does
	// - unmapped addresses read as zero
	// - read data leave a flop one clock after the strobe, else zero
	// live or buffered digit for reads
	wire held      = (hold_r != HOLD_IDLE);
	wire [3:0] hs_v = held ? buf_r[1] : dig_r[1];
	wire [3:0] ts_v = held ? buf_r[2] : dig_r[2];
	wire [3:0] ctrl_v = {1'b0, crnw_r, 1'b0, running_r};
	wire [3:0] cfg_v  = {2'b00, dir_r, cke_r};
	wire [3:0] rd_mux =
		sel_ms   ? dig_r[0] :
		sel_hs   ? hs_v :
		sel_ts   ? ts_v :
		sel_ctrl ? ctrl_v :
		sel_cfg  ? cfg_v : 4'h0;

	// configuration and run request
	always_comb begin
		cke_nxt     = cke_r;
		dir_nxt     = dir_r;
		run_req_nxt = run_req_r;
		if (wr_cfg) begin
			cke_nxt = wdata_i[`SWT_CFG_CKE_BIT];
			dir_nxt = wdata_i[`SWT_CFG_DIR_BIT];
		end
		if (dir_r) begin
			if (run_key_i) begin
				run_req_nxt = ~run_req_r;
			end
		end else if (wr_ctrl) begin
			run_req_nxt = wdata_i[`SWT_CTRL_RUN_BIT];
		end
	end

	// running state follows request only on the 1024 hz falling edge
	always_comb begin
		running_nxt = running_r;
		if (fall_1k) begin
			running_nxt = run_req_r;
		end
	end

	// drop flag: set on a correction value, consumed by next falling edge
	always_comb begin
		drop_nxt = drop_r;
		if (fall_1k & running_r & drop_r) begin
			drop_nxt = 1'b0;
		end else if (tick) begin
			drop_nxt = 1'b0;
		end
		if (cnt_rst) begin
			drop_nxt = 1'b0;
		end
	end

	// hold state machine
	// - idle: no hold, middle and top reads go live
	// - read: buffer loaded by a read or a fresh split, top read releases
	// - split: buffer renewed during a hold, top read keeps the hold
	// - only a new millisecond read leaves the split state
	// the renewal flag is rewritten on every top read, so software can
	// tell whether the three words it just read belong together
	always_comb begin
		hold_nxt = hold_r;
		crnw_nxt = crnw_r;
		case (hold_r)
			HOLD_IDLE: begin
				if (capture) begin
					hold_nxt = HOLD_READ;
				end
			end
			HOLD_READ: begin
				if (cap_split) begin
					hold_nxt = HOLD_SPLIT;
				end else if (rd_ts) begin
					hold_nxt = HOLD_IDLE;
				end
			end
			HOLD_SPLIT: begin
				if (cap_read) begin
					hold_nxt = HOLD_READ;
				end
			end
			default: begin
				hold_nxt = HOLD_IDLE;
			end
		endcase
		if (rd_ts) begin
			crnw_nxt = (hold_r == HOLD_SPLIT);
		end
		if (held & rd_ts & cap_split) begin
			hold_nxt = HOLD_SPLIT;
		end
	end

	// control flops
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cke_r     <= 1'b0;
			dir_r     <= 1'b0;
			run_req_r <= 1'b0;
			running_r <= 1'b0;
			drop_r    <= 1'b0;
			hold_r    <= HOLD_IDLE;
			crnw_r    <= 1'b0;
		end else if (clk_en_i) begin
			cke_r     <= cke_nxt;
			dir_r     <= dir_nxt;
			run_req_r <= run_req_nxt;
			running_r <= running_nxt;
			drop_r    <= drop_nxt | arm_drop;
			hold_r    <= hold_nxt;
			crnw_r    <= crnw_nxt;
		end
	end

	// reference divider, stopped while the stopwatch clock is disabled
	// one full phase is two TICK_DIV spans, so the falling event repeats
	// at the oscillator over 32 rate; the default sets that near 1024 hz
	// a disabled clock keeps divider, phase and pending drop as they are
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			div_r <= 32'h0;
			ph_r  <= 1'b0;
		end else if (clk_en_i & cke_r) begin
			div_r <= div_end ? 32'h0 : div_r + 32'h1;
			ph_r  <= div_end ? ~ph_r : ph_r;
		end
	end

	// digit counters, one generate stage each
	// stage zero counts ticks, stage one counts stage zero wraps and
	// stage two counts stage one wraps; the buffer copy of each stage
	// sits beside it so all three load on the same edge
	// a counter reset clears only the live digits, never the buffer
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_dig
			wire inc = (g == 0) ? tick : (g == 1) ? wrap0 : wrap1;
			wire top = (dig_r[g] == `SWT_DIGIT_MAX);
			always_ff @(posedge sys_clk_i or negedge resetn_i) begin
				if (!resetn_i) begin
					dig_r[g] <= `SWT_DIGIT_RST;
					buf_r[g] <= `SWT_DIGIT_RST;
				end else if (clk_en_i) begin
					if (cnt_rst) begin
						dig_r[g] <= `SWT_DIGIT_RST;
					end else if (inc) begin
						dig_r[g] <= top ? `SWT_DIGIT_RST : dig_r[g] + 4'h1;
					end
					if (capture) begin
						buf_r[g] <= dig_r[g];
					end
				end
			end
		end
	endgenerate

	// read data and carry pulses
	// carries are one clock long and suppressed by a counter reset
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rdata_r <= 4'h0;
			c1_r    <= 1'b0;
			c10_r   <= 1'b0;
		end else if (clk_en_i) begin
			rdata_r <= rd_i ? rd_mux : 4'h0;
			c1_r    <= wrap2 & ~cnt_rst;
			c10_r   <= wrap1 & ~cnt_rst;
		end
	end

	assign rdata_o      = rdata_r;
	assign carry_1hz_o  = c1_r;
	assign carry_10hz_o = c10_r;
endmodule

// ==== tb/swt_keypad.sv ====
// key pad model: debounced one-cycle split and run pulses
`timescale 1ns/100ps
module swt_keypad (
	input  wire logic clk_i,   // bench clock
	output logic      split_o, // split key
	output logic      run_o    // run toggle key
);
	initial {split_o, run_o} = 2'b00;
	// one pulse, raised and dropped right after rising edges
	task automatic press(input logic run);
		@(posedge clk_i);
		split_o <= !run;
		run_o <= run;
		@(posedge clk_i);
		{split_o, run_o} <= 2'b00;
	endtask
endmodule

// ==== tb/swt_asserts.sv ====
// port assertions for the stopwatch timer
`timescale 1ns/100ps
`include "swt_consts.svh"
module swt_checker #(
	parameter int TICK_DIV = 4 // sys clocks per half phase
) (
	input wire logic        sys_clk_i,   // clock
	input wire logic        resetn_i,    // reset
	input wire logic        clk_en_i,    // advance
	input wire logic [15:0] addr_i,      // address
	input wire logic [3:0]  wdata_i,     // write data
	input wire logic        wr_i,        // write
	input wire logic        rd_i,        // read
	input wire logic [3:0]  rdata_o,     // read data
	input wire logic        carry_1hz_o, // 1 hz carry
	input wire logic        carry_10hz_o // 10 hz carry
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);
	logic [15:0] clr_r; // enabled cycles since the digits went to zero
	// restart on a counter reset write, saturate at the top
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i)
			clr_r <= 16'h0000;
		else if (clk_en_i && wr_i && addr_i == `SWT_OFF_CTRL && wdata_i[1])
			clr_r <= 16'h0000;
		else if (clk_en_i && clr_r != 16'hffff)
			clr_r <= clr_r + 16'h0001;
	end
	rst_bit_zero_a: assert property (rd_i && clk_en_i && addr_i == `SWT_OFF_CTRL |=>
		!rdata_o[1]) else $error("reset bit reads set");
	idle_quiet_a: assert property (clk_en_i && !rd_i |=> rdata_o == 4'h0)
		else $error("read data without read");
	frozen_data_a: assert property (!clk_en_i |=> $stable(rdata_o))
		else $error("frozen data moved");
	c10_pulse_a: assert property (carry_10hz_o |=> !carry_10hz_o [*8])
		else $error("10 hz carry too long");
	c1_pulse_a: assert property (carry_1hz_o |=> !carry_1hz_o [*8])
		else $error("1 hz carry too long");
	c1_cascade_a: assert property (carry_1hz_o |-> carry_10hz_o)
		else $error("1 hz carry alone");
	c10_first_a: assert property (carry_10hz_o |-> clr_r >= 99 * 2 * TICK_DIV)
		else $error("10 hz carry too early");
	c1_first_a: assert property (carry_1hz_o |-> clr_r >= 999 * 2 * TICK_DIV)
		else $error("1 hz carry too early");
endmodule
bind bcd_stopwatch_timer swt_checker #(.TICK_DIV(TICK_DIV)) chk (.sys_clk_i(sys_clk_i),
	.resetn_i(resetn_i), .clk_en_i(clk_en_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
	.rd_i(rd_i), .rdata_o(rdata_o), .carry_1hz_o(carry_1hz_o), .carry_10hz_o(carry_10hz_o));

// ==== tb/tb_top.sv ====
// self-checking bench for the bcd stopwatch timer
`timescale 1ns/100ps
`include "swt_consts.svh"
module tb_top;
	import swt_pkg::*;
	logic        sys_clk_i, resetn_i, clk_en_i, wr_i, rd_i, rd_d, split_w, run_w, c1_w;
	logic [15:0] addr_i;
	bcd_t        wdata_i, rdata_o, exp_q[$];
	int          bad_count = 0, checked = 0, seed = 32, c1_cnt = 0;
	initial begin
		sys_clk_i = 1'b0;
		forever #10 sys_clk_i = ~sys_clk_i;
	end
	swt_keypad kp (.clk_i(sys_clk_i), .split_o(split_w), .run_o(run_w));
	bcd_stopwatch_timer #(.TICK_DIV(4)) DUT (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
		.clk_en_i(clk_en_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o), .split_key_i(split_w), .run_key_i(run_w), .carry_1hz_o(c1_w),
		.carry_10hz_o());
	task automatic check(input string nm, input bcd_t seen, input bcd_t exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic summarize();
		$display("compared %0d mismatched %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// one bus cycle; a read notes its expected data
	task automatic bus(input logic w, input logic [15:0] a, input bcd_t d);
		@(posedge sys_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= w;
		rd_i <= !w;
		if (!w)
			exp_q.push_back(d);
		@(posedge sys_clk_i);
		{wr_i, rd_i} <= 2'b00;
	endtask
	// read data stand the cycle after the strobe; compare with the oldest note
	always @(posedge sys_clk_i) begin
		c1_cnt += int'(c1_w === 1'b1);
		if (rd_d === 1'b1)
			check("rdata", rdata_o, exp_q.pop_front());
		rd_d <= rd_i;
	end
	// cut a hang short
	initial begin
		repeat (20000) @(posedge sys_clk_i);
		bad_count++;
		summarize();
	end
	initial begin
		{resetn_i, clk_en_i, wr_i, rd_i, rd_d} = 5'b01000;
		{addr_i, wdata_i} = 20'h00000;
		repeat (3) @(posedge sys_clk_i);
		resetn_i <= 1'b1;
		for (int i = 0; i < 6; i++)
			bus(0, 16'hff4b + 16'(i), 4'h0);
		bus(1, `SWT_OFF_CFG, 4'h1);
		bus(1, `SWT_OFF_MS, 4'($random(seed)));
		bus(1, `SWT_OFF_CTRL, 4'h2);
		bus(0, `SWT_OFF_CTRL, 4'h0);
		bus(0, `SWT_OFF_MS, 4'h0);
		bus(1, `SWT_OFF_CTRL, 4'h1);
		repeat (300) @(posedge sys_clk_i);
		bus(0, `SWT_OFF_HS, 4'h0);
		bus(0, `SWT_OFF_TS, 4'h0);
		bus(0, `SWT_OFF_CTRL, 4'h1);
		$display("done hold");
		clk_en_i <= 1'b0;
		repeat (5 + $unsigned($random(seed)) % 20) @(posedge sys_clk_i);
		clk_en_i <= 1'b1;
		repeat (9000) @(posedge sys_clk_i);
		check("carry_1hz", bcd_t'(c1_cnt), 4'h1);
		$display("done counting");
		bus(1, `SWT_OFF_CTRL, 4'h0);
		repeat (20) @(posedge sys_clk_i);
		bus(1, `SWT_OFF_CTRL, 4'h2);
		repeat (20) @(posedge sys_clk_i);
		bus(0, `SWT_OFF_HS, 4'h0);
		kp.press(1'b0);
		kp.press(1'b0);
		bus(1, `SWT_OFF_CTRL, 4'h1);
		repeat (300) @(posedge sys_clk_i);
		bus(0, `SWT_OFF_TS, 4'h0);
		bus(0, `SWT_OFF_CTRL, 4'h5);
		bus(0, `SWT_OFF_HS, 4'h0);
		bus(0, `SWT_OFF_TS, 4'h0);
		bus(0, `SWT_OFF_CTRL, 4'h5);
		$display("done split");
		bus(1, `SWT_OFF_CFG, 4'h3);
		bus(1, `SWT_OFF_CTRL, 4'h0);
		repeat (20) @(posedge sys_clk_i);
		bus(0, `SWT_OFF_CTRL, 4'h5);
		kp.press(1'b1);
		repeat (20) @(posedge sys_clk_i);
		bus(0, `SWT_OFF_CTRL, 4'h4);
		$display("done direct");
		repeat (2) @(posedge sys_clk_i);
		summarize();
	end
endmodule
